// ---- hmc_map.vh ----
/*
 * register offsets, field positions, reset values and timing counts of the
 * monitor configuration and interrupt block.
 * assumes a 200 MHz aclk and AXI4-Lite word addressing (byte addr = 4 * index).
 */
`ifndef HMC_MAP_VH
`define HMC_MAP_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define HMC_IDX_CFG 8'h40
`define HMC_IDX_STAT1 8'h41
`define HMC_IDX_STAT2 8'h42
`define HMC_IDX_MASK1 8'h43
`define HMC_IDX_MASK2 8'h44
`define HMC_IDX_CICLR 8'h46
`define HMC_IDX_FANDIV 8'h47
`define HMC_IDX_TCFG 8'h4B
`define HMC_IDX_DEVID 8'h3E

// ----------------------------------------
// reset values
// ----------------------------------------
`define HMC_RST_CFG 8'h08
`define HMC_RST_STAT 8'h00
`define HMC_RST_MASK 8'h00
`define HMC_RST_CICLR 8'h00
`define HMC_RST_FANDIV 4'h5
`define HMC_RST_TCFG 8'h01
// arbitrary neutral identity value
`define HMC_DEVICE_ID 8'h5A

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define HMC_CFG_START 0
`define HMC_CFG_IRQ_EN 1
`define HMC_CFG_IRQ_CLR 3
`define HMC_CFG_RST_REQ 4
`define HMC_CFG_INTR_REQ 6
`define HMC_CFG_INIT 7
`define HMC_CFG_RW_MASK 8'h0B
`define HMC_MASK2_RST_EN 7
`define HMC_CICLR_REQ 7
`define HMC_STAT1_VALID 8'hDF
`define HMC_STAT2_VALID 8'h13

// ----------------------------------------
// timing
// ----------------------------------------
`define HMC_PULSE_MS 20
`define HMC_CLK_KHZ 200000
`define HMC_PULSE_CYC (`HMC_PULSE_MS * `HMC_CLK_KHZ)

`endif

// ---- hmc_monitor_ctrl.v ----
/*
 * configuration and interrupt logic of a system hardware monitor: scan run
 * control, latched limit flags, masked active-low interrupt, reset and
 * chassis intrusion pulses, register restore.
 * assumes an AXI4-Lite master with one write and one read outstanding, and
 * fault events from comparators on aclk (asynchronous pin inputs are synced).
 */
// What this block does
// - start bit runs scanning, else standby
// - clearing start never drops interrupt pin
// - config bit 1 gates interrupt pin
// - interrupt clear bit deasserts pin, keeps status
// - interrupt clear bit halts monitoring, reset one
// - bit 4 drives reset low 20 ms
// - bit 6 pulses intrusion pin low 20 ms
// - bit 7 restores defaults, reads zero
// - voltage limit faults set status flags
// - temperature fault sets status one bit 4
// - fan faults set status one bits 6,7
// - intrusion rising edge sets status two bit 4
// - both status registers reset to zero
// - status read clears returned flags
// - pending unhandled fault raises new indication
// - mask one bit blocks matching flag
// - intrusion clear register bit self-clears after pulse
// - reset request needs mask two bit 7
`timescale 1ns/1ps
`include "hmc_map.vh"

module hmc_monitor_ctrl #(
	parameter [31:0] PULSE_CYC = `HMC_PULSE_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [5:0] rail_fault,
	input wire temp_fault,
	input wire fan_a_fault,
	input wire fan_b_fault,
	input wire intrusion_pin_in,
	output wire intrusion_pin_out,
	output wire intrusion_pin_oe,
	output wire reset_n,
	output wire irq_n,
	output wire monitor_run
);

// ----------------------------------------
// register state
// ----------------------------------------
reg [7:0] cfg_q;
reg [7:0] stat1_q;
reg [7:0] stat2_q;
reg [7:0] mask1_q;
reg [7:0] mask2_q;
reg [7:0] ciclr_q;
reg [3:0] fandiv_q;
reg [7:0] tcfg_q;
reg [31:0] rst_cnt_q;
reg [31:0] ci_cnt_q;
reg ci_s1_q;
reg ci_s2_q;
reg ci_s3_q;

// ----------------------------------------
// axi write channel
// ----------------------------------------
reg [11:0] awaddr_q;
reg aw_have_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg w_have_q;
reg bvalid_q;
reg [1:0] bresp_q;
wire wr_fire;
wire [9:0] wr_idx;
wire wr_hit;

assign s_axi_awready = !aw_have_q && !bvalid_q;
assign s_axi_wready = !w_have_q && !bvalid_q;
assign s_axi_bvalid = bvalid_q;
assign s_axi_bresp = bresp_q;
assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
assign wr_idx = awaddr_q[11:2];
assign wr_hit = wr_fire && wstrb_q[0] && (awaddr_q[1:0] == 2'b00);

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_have_q <= 1'b0;
		w_have_q <= 1'b0;
		awaddr_q <= 12'h000;
		wdata_q <= 32'h0000_0000;
		wstrb_q <= 4'h0;
		bvalid_q <= 1'b0;
		bresp_q <= 2'b00;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b1;
			if (wr_idx == {2'b00, `HMC_IDX_CFG} || wr_idx == {2'b00, `HMC_IDX_MASK1} ||
				wr_idx == {2'b00, `HMC_IDX_MASK2} || wr_idx == {2'b00, `HMC_IDX_CICLR} ||
				wr_idx == {2'b00, `HMC_IDX_FANDIV} || wr_idx == {2'b00, `HMC_IDX_TCFG} ||
				wr_idx == {2'b00, `HMC_IDX_STAT1} || wr_idx == {2'b00, `HMC_IDX_STAT2}) begin
				bresp_q <= 2'b00;
			end else begin
				bresp_q <= 2'b10;
			end
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
end

// ----------------------------------------
// axi read channel
// ----------------------------------------
reg rvalid_q;
reg [31:0] rdata_q;
reg [1:0] rresp_q;
reg [7:0] rd_val;
reg rd_ok;
wire rd_fire;
wire [9:0] rd_idx;
wire rd_stat1;
wire rd_stat2;

assign s_axi_arready = !rvalid_q;
assign s_axi_rvalid = rvalid_q;
assign s_axi_rdata = rdata_q;
assign s_axi_rresp = rresp_q;
assign rd_fire = s_axi_arvalid && !rvalid_q;
assign rd_idx = s_axi_araddr[11:2];
assign rd_stat1 = rd_fire && rd_idx == {2'b00, `HMC_IDX_STAT1};
assign rd_stat2 = rd_fire && rd_idx == {2'b00, `HMC_IDX_STAT2};

always @* begin
	rd_val = 8'h00;
	rd_ok = 1'b1;
	if (rd_idx == {2'b00, `HMC_IDX_CFG}) begin
		rd_val = cfg_q & `HMC_CFG_RW_MASK;
	end else if (rd_idx == {2'b00, `HMC_IDX_STAT1}) begin
		rd_val = stat1_q;
	end else if (rd_idx == {2'b00, `HMC_IDX_STAT2}) begin
		rd_val = stat2_q;
	end else if (rd_idx == {2'b00, `HMC_IDX_MASK1}) begin
		rd_val = mask1_q;
	end else if (rd_idx == {2'b00, `HMC_IDX_MASK2}) begin
		rd_val = mask2_q;
	end else if (rd_idx == {2'b00, `HMC_IDX_CICLR}) begin
		rd_val = ciclr_q;
	end else if (rd_idx == {2'b00, `HMC_IDX_FANDIV}) begin
		rd_val = {fandiv_q, 4'h0};
	end else if (rd_idx == {2'b00, `HMC_IDX_TCFG}) begin
		rd_val = tcfg_q;
	end else if (rd_idx == {2'b00, `HMC_IDX_DEVID}) begin
		rd_val = `HMC_DEVICE_ID;
	end else begin
		rd_ok = 1'b0;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		rvalid_q <= 1'b0;
		rdata_q <= 32'h0000_0000;
		rresp_q <= 2'b00;
	end else if (rd_fire) begin
		rvalid_q <= 1'b1;
		rdata_q <= {24'h00_0000, rd_val};
		rresp_q <= rd_ok ? 2'b00 : 2'b10;
	end else if (rvalid_q && s_axi_rready) begin
		rvalid_q <= 1'b0;
	end
end

// ----------------------------------------
// writes to control registers
// ----------------------------------------
wire init_req;
wire cfg_wr;
wire rst_fire;
wire ci_fire;

assign cfg_wr = wr_hit && wr_idx == {2'b00, `HMC_IDX_CFG};
assign init_req = cfg_wr && wdata_q[`HMC_CFG_INIT];
// reset request only honoured with mask two enable set
assign rst_fire = cfg_wr && wdata_q[`HMC_CFG_RST_REQ] && mask2_q[`HMC_MASK2_RST_EN];
assign ci_fire = (cfg_wr && wdata_q[`HMC_CFG_INTR_REQ]) ||
	(wr_hit && wr_idx == {2'b00, `HMC_IDX_CICLR} && wdata_q[`HMC_CICLR_REQ]);

always @(posedge aclk) begin
	if (!aresetn || init_req) begin
		cfg_q <= `HMC_RST_CFG;
		mask1_q <= `HMC_RST_MASK;
		mask2_q <= `HMC_RST_MASK;
		fandiv_q <= `HMC_RST_FANDIV;
		tcfg_q <= `HMC_RST_TCFG;
	end else begin
		if (cfg_wr) begin
			// request bits fire pulses and never store
			cfg_q <= wdata_q[7:0] & `HMC_CFG_RW_MASK;
		end
		if (wr_hit && wr_idx == {2'b00, `HMC_IDX_MASK1}) begin
			mask1_q <= wdata_q[7:0] & 8'hDF;
		end
		if (wr_hit && wr_idx == {2'b00, `HMC_IDX_MASK2}) begin
			mask2_q <= wdata_q[7:0];
		end
		if (wr_hit && wr_idx == {2'b00, `HMC_IDX_FANDIV}) begin
			fandiv_q <= wdata_q[7:4];
		end
		if (wr_hit && wr_idx == {2'b00, `HMC_IDX_TCFG}) begin
			tcfg_q <= wdata_q[7:0];
		end
	end
end

// ----------------------------------------
// output pulses
// ----------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		rst_cnt_q <= 32'h0000_0000;
		ci_cnt_q <= 32'h0000_0000;
		ciclr_q <= `HMC_RST_CICLR;
	end else begin
		if (rst_fire) begin
			rst_cnt_q <= PULSE_CYC;
		end else if (rst_cnt_q != 32'h0000_0000) begin
			rst_cnt_q <= rst_cnt_q - 32'h0000_0001;
		end
		if (ci_fire) begin
			ci_cnt_q <= PULSE_CYC;
		end else if (ci_cnt_q != 32'h0000_0000) begin
			ci_cnt_q <= ci_cnt_q - 32'h0000_0001;
		end
		// request bit reads one until the pulse has ended
		if (ci_fire && wr_idx == {2'b00, `HMC_IDX_CICLR}) begin
			ciclr_q <= 8'h80;
		end else if (ci_cnt_q == 32'h0000_0001) begin
			ciclr_q <= `HMC_RST_CICLR;
		end
	end
end

assign reset_n = (rst_cnt_q == 32'h0000_0000);
assign intrusion_pin_out = 1'b0;
assign intrusion_pin_oe = (ci_cnt_q != 32'h0000_0000);

// ----------------------------------------
// intrusion sync and status flags
// ----------------------------------------
wire [7:0] ev1;
wire [7:0] ev2;
wire ci_rise;

always @(posedge aclk) begin
	if (!aresetn) begin
		ci_s1_q <= 1'b0;
		ci_s2_q <= 1'b0;
		ci_s3_q <= 1'b0;
	end else begin
		ci_s1_q <= intrusion_pin_in;
		ci_s2_q <= ci_s1_q;
		ci_s3_q <= ci_s2_q;
	end
end

// own pulse drives the pin low, so a rise then is ignored
assign ci_rise = ci_s2_q && !ci_s3_q && !intrusion_pin_oe;
// monitoring runs only with start set and interrupt clear low
assign monitor_run = cfg_q[`HMC_CFG_START] && !cfg_q[`HMC_CFG_IRQ_CLR];
assign ev1 = monitor_run ? {fan_b_fault, fan_a_fault, 1'b0, temp_fault, rail_fault[3:0]} :
	8'h00;
assign ev2 = {3'b000, ci_rise, 2'b00,
	monitor_run ? rail_fault[5:4] : 2'b00};

always @(posedge aclk) begin
	if (!aresetn || init_req) begin
		stat1_q <= `HMC_RST_STAT;
		stat2_q <= `HMC_RST_STAT;
	end else begin
		// a fault still present re-sets its flag after the read clears it
		stat1_q <= ((rd_stat1 ? 8'h00 : stat1_q) | ev1) & `HMC_STAT1_VALID;
		stat2_q <= ((rd_stat2 ? 8'h00 : stat2_q) | ev2) & `HMC_STAT2_VALID;
	end
end

// ----------------------------------------
// interrupt pin
// ----------------------------------------
reg irq_n_q;
wire irq_any;

assign irq_any = |(stat1_q & ~mask1_q) ||
	|(stat2_q & ~{3'b000, mask2_q[4], 2'b00, mask2_q[1:0]});

// start bit plays no part here, so clearing it keeps the pin low
always @(posedge aclk) begin
	if (!aresetn) begin
		irq_n_q <= 1'b1;
	end else begin
		irq_n_q <= !(irq_any && cfg_q[`HMC_CFG_IRQ_EN] && !cfg_q[`HMC_CFG_IRQ_CLR]);
	end
end

assign irq_n = irq_n_q;

endmodule

// ---- hmc_monitor_ctrl_assertions.sv ----
/* checker for hmc_monitor_ctrl: bus handshakes, read data width, pulse widths.
   bound to the design; PULSE_CYC is handed on from the design instance. */
`timescale 1ns/1ps
module hmc_ctrl_chk #(
	parameter [31:0] PULSE_CYC = 20
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire intrusion_pin_out,
	input wire intrusion_pin_oe,
	input wire reset_n
);
	// ----
	// pulse length counters
	// ----
	reg [31:0] rc_q;
	reg [31:0] cc_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			rc_q <= 32'h0000_0000;
			cc_q <= 32'h0000_0000;
		end else begin
			rc_q <= reset_n ? 32'h0000_0000 : rc_q + 1;
			cc_q <= intrusion_pin_oe ? cc_q + 1 : 32'h0000_0000;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ci_pin_low: assert property (intrusion_pin_out == 1'b0)
		else $error("intrusion pin driven high");
	a_rst_width: assert property ($rose(reset_n) |-> rc_q == PULSE_CYC)
		else $error("reset pulse width wrong");
	a_ci_width: assert property ($fell(intrusion_pin_oe) |-> cc_q == PULSE_CYC)
		else $error("intrusion pulse width wrong");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule
bind hmc_monitor_ctrl hmc_ctrl_chk #(.PULSE_CYC(PULSE_CYC)) i_hmc_ctrl_chk (.*);

// ---- hmc_tb.sv ----
/* self-checking bench for hmc_monitor_ctrl over AXI4-Lite.
   assumes hmc_map.vh on the include path and a 20 cycle pulse. */
`timescale 1ns/1ps
`include "hmc_map.vh"
module tb;
reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
reg [11:0] s_axi_awaddr, s_axi_araddr;
reg [31:0] s_axi_wdata;
reg [3:0] s_axi_wstrb;
reg [5:0] rail_fault;
reg temp_fault, fan_a_fault, fan_b_fault, ci_ext;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire intrusion_pin_out, intrusion_pin_oe, reset_n, irq_n, monitor_run;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
integer miscompares = 0, n_tests = 0, i;
reg [1:0] rr, rb;
// the block's own pulse wins over the external latch
wire intrusion_pin_in = intrusion_pin_oe ? intrusion_pin_out : ci_ext;
hmc_monitor_ctrl #(.PULSE_CYC(20)) i_hmc_monitor_ctrl (.*);
initial begin
	aclk = 0;
	forever #2.5 aclk = ~aclk;
end
function [11:0] a(input [7:0] x);
	a = {2'b00, x, 2'b00};
endfunction
// ----
// checks and bus tasks
// ----
task chk(input [31:0] g, input [31:0] e);
	begin
		n_tests = n_tests + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	end
endtask
task results;
	begin
		if (miscompares == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	end
endtask
task wr(input [7:0] x, input [7:0] d);
	integer k;
	reg b;
	begin
		s_axi_awaddr <= a(x);
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1;
		for (k = 0; k < 40 && b; k = k + 1) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rb = s_axi_bresp;
				s_axi_bready <= 1'b0;
				b = 0;
			end
		end
		if (b) begin
			miscompares = miscompares + 1;
			results;
		end
		@(posedge aclk);
	end
endtask
// an expected value of all x skips the data compare
task rd(input [7:0] x, input [7:0] e);
	integer k;
	reg b;
	begin
		s_axi_araddr <= a(x);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		b = 1;
		for (k = 0; k < 40 && b; k = k + 1) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				if (e !== 8'hxx) chk(s_axi_rdata, {24'h00_0000, e});
				rr = s_axi_rresp;
				s_axi_rready <= 1'b0;
				b = 0;
			end
		end
		if (b) begin
			miscompares = miscompares + 1;
			results;
		end
		@(posedge aclk);
	end
endtask
// ----
// scenarios
// ----
task t_rst;
	begin
		rd(`HMC_IDX_CFG, 8'h08);
		rd(`HMC_IDX_STAT1, 8'h00);
		rd(`HMC_IDX_STAT2, 8'h00);
		chk(irq_n, 1);
		chk(monitor_run, 0);
	end
endtask
task t_irq;
	begin
		wr(`HMC_IDX_CFG, 8'h01);
		chk(monitor_run, 1);
		fan_a_fault <= 1'b1;
		@(posedge aclk);
		fan_a_fault <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(irq_n, 1);
		wr(`HMC_IDX_CFG, 8'h03);
		chk(irq_n, 0);
		wr(`HMC_IDX_CFG, 8'h02);
		chk(monitor_run, 0);
		chk(irq_n, 0);
		wr(`HMC_IDX_CFG, 8'h0B);
		chk(irq_n, 1);
		chk(monitor_run, 0);
		rd(`HMC_IDX_STAT1, 8'h40);
		rd(`HMC_IDX_STAT1, 8'h00);
		wr(`HMC_IDX_CFG, 8'h03);
		wr(`HMC_IDX_MASK1, 8'hFF);
		rd(`HMC_IDX_MASK1, 8'hDF);
		fan_b_fault <= 1'b1;
		temp_fault <= 1'b1;
		@(posedge aclk);
		fan_b_fault <= 1'b0;
		temp_fault <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(irq_n, 1);
		rd(`HMC_IDX_STAT1, 8'h90);
		wr(`HMC_IDX_MASK1, 8'h00);
	end
endtask
task t_rail;
	begin
		for (i = 0; i < 6; i = i + 1) begin
			rail_fault <= 6'h01 << i;
			repeat (2) @(posedge aclk);
			rd(i < 4 ? `HMC_IDX_STAT1 : `HMC_IDX_STAT2, 8'h01 << (i % 4));
			rail_fault <= 6'h00;
			rd(i < 4 ? `HMC_IDX_STAT1 : `HMC_IDX_STAT2, 8'h01 << (i % 4));
			rd(i < 4 ? `HMC_IDX_STAT1 : `HMC_IDX_STAT2, 8'h00);
		end
		ci_ext <= 1'b1;
		repeat (5) @(posedge aclk);
		rd(`HMC_IDX_STAT2, 8'h10);
		ci_ext <= 1'b0;
	end
endtask
task t_ro;
	begin
		wr(`HMC_IDX_STAT1, 8'hFF);
		chk(rb, 0);
		rd(`HMC_IDX_STAT1, 8'h00);
		wr(`HMC_IDX_CFG, 8'h34);
		chk(reset_n, 1);
		rd(`HMC_IDX_CFG, 8'h00);
		rd(8'h50, 8'hxx);
		chk(rr, 2);
		wr(8'h50, 8'h00);
		chk(rb, 2);
	end
endtask
task t_pls;
	begin
		wr(`HMC_IDX_MASK2, 8'h80);
		wr(`HMC_IDX_CFG, 8'h10);
		chk(reset_n, 0);
		rd(`HMC_IDX_CFG, 8'h00);
		repeat (20) @(posedge aclk);
		chk(reset_n, 1);
		wr(`HMC_IDX_CICLR, 8'h80);
		chk(intrusion_pin_oe, 1);
		rd(`HMC_IDX_CICLR, 8'h80);
		repeat (20) @(posedge aclk);
		rd(`HMC_IDX_CICLR, 8'h00);
		wr(`HMC_IDX_CFG, 8'h40);
		chk(intrusion_pin_oe, 1);
		repeat (20) @(posedge aclk);
		chk(intrusion_pin_oe, 0);
		rd(`HMC_IDX_CFG, 8'h00);
	end
endtask
task t_ini;
	begin
		ci_ext <= 1'b1;
		wr(`HMC_IDX_MASK1, 8'h0F);
		wr(`HMC_IDX_FANDIV, 8'hA0);
		wr(`HMC_IDX_TCFG, 8'h00);
		rd(`HMC_IDX_FANDIV, 8'hA0);
		wr(`HMC_IDX_CFG, 8'h83);
		rd(`HMC_IDX_CFG, 8'h08);
		rd(`HMC_IDX_MASK1, 8'h00);
		rd(`HMC_IDX_MASK2, 8'h00);
		rd(`HMC_IDX_STAT2, 8'h00);
		rd(`HMC_IDX_FANDIV, 8'h50);
		rd(`HMC_IDX_TCFG, 8'h01);
		ci_ext <= 1'b0;
	end
endtask
initial begin
	aresetn = 0;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	s_axi_awaddr = 12'h000;
	s_axi_araddr = 12'h000;
	s_axi_wdata = 32'h0000_0000;
	s_axi_wstrb = 4'hF;
	rail_fault = 6'h00;
	{temp_fault, fan_a_fault, fan_b_fault, ci_ext} = 4'h0;
	repeat (6) @(posedge aclk);
	aresetn <= 1'b1;
	t_rst;
	t_irq;
	t_rail;
	t_ro;
	t_pls;
	t_ini;
	results;
end
endmodule
